// ===== verilog/vip_pkg.sv
// package for the interrupt preprocessor: level codes, state enumeration
// assumes a single 20 MHz clock domain and active-high internal signal levels
package vip_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int IRQ_LINES = 7;
	localparam int LEVEL_W = 3;
	localparam int STATUS_W = 8;
	localparam logic [2:0] LEVEL_NONE = 3'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	typedef enum logic [2:0] {
		VIP_IDLE,
		VIP_REQUEST,
		VIP_ACK,
		VIP_SERVICE
	} vip_state_t;
endpackage

// ===== verilog/vip_level_encoder.sv
// priority encoder: highest active request line to a 3-bit level code
// assumes request lines are active-high levels synchronous to clk_sys
`timescale 1ns/10ps
module vip_level_encoder
	import vip_pkg::*;
(
	input wire logic [6:0] irq_request_lines,
	output logic [2:0] level
);
	// all lines resolved in parallel, purely combinational
	function automatic logic [2:0] top_level(input logic [6:0] req);
		logic [2:0] lv;
		lv = LEVEL_NONE;
		for (int i = 0; i < IRQ_LINES; i++) begin
			if (req[i]) begin
				lv = 3'(i + 1);
			end
		end
		return lv;
	endfunction

	assign level = top_level(irq_request_lines); // RL1 RL2 RL3
endmodule

// ===== verilog/vip_irq_preprocessor.sv
// interrupt-handling preprocessor: bus request, ownership, acknowledge cycle,
// status byte capture and start-service handshake toward the local handler
// assumes all inputs synchronous to clk_sys, active high inside this block
// assumes the grant and dtack answers arrive as levels that stand until released
// outputs are active-high levels; bus drivers outside invert them for the backplane
// Functional notes
// RL1 - with bus owned and line seven active, level code is 111
// RL2 - level code is the highest active line; line one alone gives 001
// RL3 - all request lines resolved in parallel within one clock
// RL4 - when owning bus, drive level code on address and assert data strobes; code asserts data_strobe from the second owned cycle on
// RL5 - while bus ownership held, assert iack to start daisy chain; code asserts iack from the second owned cycle on
// RL6 - whenever iack asserted, assert address strobe
// RL7 - interrupter asserts dtack with byte valid; then capture strobe asserts
// RL8 - capture strobe stores the 8-bit status byte into a register
// RL9 - start-service held after capture until handler reports done
// RL10 - any active request line asserts level-three bus request
// RL11 - busy asserted on request plus grant, held until service done
// RL12 - reset deasserts request, busy, acknowledge, strobes, capture, start-service
`timescale 1ns/10ps
module vip_irq_preprocessor
	import vip_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [6:0] irq_request_lines,
	input wire logic bus_grant_in,
	input wire logic dtack,
	input wire logic [7:0] data_bus,
	input wire logic service_done,
	output logic bus_request,
	output logic bus_busy,
	output logic iack,
	output logic addr_strobe,
	output logic data_strobe,
	output logic [2:0] ack_level_code,
	output logic capture_strobe,
	output logic [7:0] status_byte,
	output logic start_service
);
	logic [2:0] level;
	logic any_req;
	logic busy_reg;
	logic busy_next;
	logic req_reg;
	logic req_next;
	logic cap_reg;
	logic cap_next;
	logic start_reg;
	logic start_next;
	logic [2:0] code_reg;
	logic [2:0] code_next;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	vip_state_t state_reg;
	vip_state_t state_next;

	// named decodes shared by the next-state terms and the outputs
	logic in_request;
	logic in_ack;
	logic in_service;
	logic ack_phase;
	logic owned_ack;
	logic grant_taken;
	logic keep_bus;
	logic code_load;
	logic capture_event;
	logic status_load;
	logic hold_start;

	vip_level_encoder u_enc (
		.irq_request_lines(irq_request_lines),
		.level(level)
	);

	assign in_request = (state_reg == VIP_REQUEST);
	assign in_ack = (state_reg == VIP_ACK);
	assign in_service = (state_reg == VIP_SERVICE);
	// acknowledge phase covers the dtack wait and the service wait
	assign ack_phase = in_ack || in_service; // RL5

	assign any_req = |irq_request_lines; // RL10
	// request held while lines are active and the bus is not yet ours
	assign req_next = any_req && !busy_next; // RL10
	// ownership taken on request plus grant, kept until service is done
	assign grant_taken = req_reg && bus_grant_in; // RL11
	assign keep_bus = busy_reg && !service_done; // RL11
	assign busy_next = grant_taken || keep_bus; // RL11

	// level sampled once, at the first owned cycle, then frozen for the cycle
	assign code_load = busy_reg && in_request; // RL1 RL2
	assign code_next = code_load ? level : code_reg; // RL1 RL2
	// a dtack held over several cycles still gives a single capture pulse
	assign capture_event = busy_reg && dtack && in_ack && !cap_reg; // RL7
	assign cap_next = capture_event; // RL7
	assign status_load = cap_reg; // RL8
	assign status_next = status_load ? data_bus : status_reg; // RL8

	// start request kept until the handler reports done
	assign hold_start = start_reg && !service_done; // RL9
	assign start_next = busy_next && (cap_reg || hold_start); // RL9

	// idle, request until owned, acknowledge until dtack, service until done;
	// losing the bus early falls back to idle and clears the acknowledge outputs
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			VIP_IDLE: begin
				if (any_req) begin
					state_next = VIP_REQUEST;
				end
			end
			VIP_REQUEST: begin
				if (busy_reg) begin
					state_next = VIP_ACK;
				end else if (!any_req) begin
					state_next = VIP_IDLE;
				end
			end
			VIP_ACK: begin
				if (cap_reg) begin
					state_next = VIP_SERVICE;
				end else if (!busy_reg) begin
					state_next = VIP_IDLE;
				end
			end
			VIP_SERVICE: begin
				if (!busy_reg) begin
					state_next = VIP_IDLE;
				end
			end
			default: begin
				state_next = VIP_IDLE;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= VIP_IDLE; // RL12
		end else begin
			state_reg <= state_next;
		end
	end

	// bus request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			req_reg <= 1'h0; // RL12
		end else begin
			req_reg <= req_next;
		end
	end

	// bus ownership
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_reg <= 1'h0; // RL12
		end else begin
			busy_reg <= busy_next;
		end
	end

	// capture strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cap_reg <= 1'h0; // RL12
		end else begin
			cap_reg <= cap_next;
		end
	end

	// start-service request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_reg <= 1'h0; // RL12
		end else begin
			start_reg <= start_next;
		end
	end

	// latched acknowledge level
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			code_reg <= LEVEL_NONE;
		end else begin
			code_reg <= code_next;
		end
	end

	// captured status byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_reg <= STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// registered arbitration outputs
	assign bus_request = req_reg; // RL10
	assign bus_busy = busy_reg; // RL11

	// acknowledge outputs valid only once the level code is latched
	assign owned_ack = busy_reg && ack_phase; // RL5
	assign iack = owned_ack; // RL5
	// interrupters read the level code while the strobes are up
	assign addr_strobe = iack; // RL6
	assign data_strobe = owned_ack; // RL4
	assign ack_level_code = code_reg; // RL4

	// capture pulse, captured byte and start request toward the handler
	assign capture_strobe = cap_reg; // RL7
	assign status_byte = status_reg; // RL8
	assign start_service = start_reg; // RL9
endmodule

// ===== bench/vip_sva.sv
// checker: bus ownership and acknowledge timing
// bound to the preprocessor, sees its ports only
`timescale 1ns/10ps
module vip_sva(
	input logic clk_sys,
	input logic rst,
	input logic [6:0] irq_request_lines,
	input logic bus_grant_in,
	input logic dtack,
	input logic [7:0] data_bus,
	input logic service_done,
	input logic bus_request,
	input logic bus_busy,
	input logic iack,
	input logic addr_strobe,
	input logic data_strobe,
	input logic [2:0] ack_level_code,
	input logic capture_strobe,
	input logic [7:0] status_byte,
	input logic start_service
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_rq; !bus_busy && |irq_request_lines |=> bus_request || bus_busy; endproperty
	a_rq: assert property (p_rq) else $error("no request");
	property p_bb; bus_request && bus_grant_in |=> bus_busy; endproperty
	a_bb: assert property (p_bb) else $error("no busy");
	property p_hd; bus_busy && !service_done |=> bus_busy; endproperty
	a_hd: assert property (p_hd) else $error("busy lost");
	property p_ia; $rose(bus_busy) |-> ##2 iack; endproperty
	a_ia: assert property (p_ia) else $error("no iack");
	property p_as; iack |-> addr_strobe; endproperty
	a_as: assert property (p_as) else $error("no strobe");
	property p_cp; iack && $rose(dtack) |=> capture_strobe; endproperty
	a_cp: assert property (p_cp) else $error("no capture");
	property p_st; capture_strobe |=> status_byte == $past(data_bus) && start_service; endproperty
	a_st: assert property (p_st) else $error("bad byte");
	property p_dn; start_service && service_done |=> !start_service && !bus_busy; endproperty
	a_dn: assert property (p_dn) else $error("no release");
	property p_ds; iack |-> data_strobe && ack_level_code != 3'h0; endproperty
	a_ds: assert property (p_ds) else $error("no data strobe");
	property p_ih; iack |=> iack || !bus_busy; endproperty
	a_ih: assert property (p_ih) else $error("iack lost");
	property p_l7; $rose(bus_busy) && irq_request_lines[6] |=> ack_level_code == 3'h7; endproperty
	a_l7: assert property (p_l7) else $error("level not seven");
	property p_l1; $rose(bus_busy) && irq_request_lines == 7'h01 |=> ack_level_code == 3'h1;
	endproperty
	a_l1: assert property (p_l1) else $error("level not one");
	property p_c1; capture_strobe |=> !capture_strobe; endproperty
	a_c1: assert property (p_c1) else $error("capture too long");
endmodule
bind vip_irq_preprocessor vip_sva u_sva (.*);

// ===== bench/vip_partner.sv
// partner: interrupter answering the acknowledge, handler finishing service
// assumes clk_sys and rst of the bench
`timescale 1ns/10ps
module vip_partner(
	input logic clk_sys,
	input logic rst,
	input logic iack,
	input logic start_service,
	input logic [7:0] id_byte,
	output logic dtack,
	output logic [7:0] data_bus,
	output logic service_done
);
	assign data_bus = dtack ? id_byte : ~id_byte;
	always_ff @(posedge clk_sys) begin
		dtack <= !rst && !start_service && (iack || dtack);
		service_done <= start_service;
	end
endmodule

// ===== bench/testbench.sv
// testbench: random request patterns against an integer priority model
// assumes the partner answers acknowledge and service
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 0, rst = 1, bus_grant_in, dtack, service_done, bus_request, bus_busy;
	logic iack, addr_strobe, data_strobe, capture_strobe, start_service;
	logic [6:0] irq_request_lines = 0;
	logic [7:0] id_byte = 0, data_bus, status_byte;
	logic [2:0] ack_level_code;
	logic [15:0] r = 16'hc92d;
	int miscompares = 0, n_checks = 0, e, n;
	int exp_q[$];
	assign bus_grant_in = bus_request;
	always #25 clk_sys = ~clk_sys;
	vip_irq_preprocessor uut (.*);
	vip_partner u_far (.*);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input string nm, input int x, input logic [7:0] g);
		n_checks++;
		if (g !== x[7:0]) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", nm, x, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		chk("reset", 0, {1'h0, bus_request, bus_busy, iack, addr_strobe, data_strobe,
			capture_strobe, start_service});
		rst = 0;
		for (int i = 0; i < 12; i++) begin
			@(negedge clk_sys);
			r = lfsr(r);
			irq_request_lines = (i == 0) ? 7'h01 : r[6:0] | 7'h01;
			id_byte = r[15:8];
			exp_q.push_back(r[15:8]);
			e = 0;
			for (int k = 0; k < 7; k++) if (irq_request_lines[k]) e = k + 1;
			for (n = 0; n < 30 && start_service !== 1'b1; n++) @(negedge clk_sys);
			if (n == 30) begin
				miscompares++;
				break;
			end
			chk("level", e, {5'h0, ack_level_code});
			chk("byte", exp_q.pop_front(), status_byte);
			irq_request_lines = 0;
			if (i == 5) begin
				rst = 1;
				repeat (2) @(negedge clk_sys);
				chk("reset", 0, {1'h0, bus_request, bus_busy, iack, addr_strobe, data_strobe,
					capture_strobe, start_service});
				rst = 0;
			end
			for (n = 0; n < 30 && bus_busy !== 1'b0; n++) @(negedge clk_sys);
			if (n == 30) begin
				miscompares++;
				break;
			end
			chk("busy", 0, {7'h0, bus_busy});
			chk("start", 0, {7'h0, start_service});
		end
		end_of_test();
	end
endmodule
